/* File: core/remoting_pkg.sv */
// shared types and constants for the unit header framer
`default_nettype none

package remoting_pkg;

    // ------------------------------------------------------------
    // header layout, word 0 first, most significant bit first
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] version;
        logic control;
        logic extended;
        logic [2:0] reserved_control_bits;
        logic [23:0] channel_identifier;
        logic [5:0] channel_protocol_type;
        logic [1:0] reserved_header_bits;
        logic [1:0] segment_position_bits;
        logic response_flag;
        logic [4:0] command_code;
        logic [15:0] total_unit_length;
        logic [31:0] channel_timestamp;
        logic [15:0] sequence_number;
        logic [15:0] received_sequence;
    } hdr_t;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int HDR_BITS = 128;
    localparam logic [3:0] HDR_LAST_BYTE = 4'hf;
    localparam logic [15:0] HDR_LEN = 16'h0010;
    localparam logic [2:0] VERSION_ONE = 3'h0;
    localparam logic [2:0] RSV_CTRL_ZERO = 3'h0;
    localparam logic [1:0] RSV_HDR_ZERO = 2'h0;
    localparam logic [1:0] SEG_FULL = 2'h0;
    localparam logic [1:0] SEG_FIRST = 2'h1;
    localparam logic [1:0] SEG_LAST = 2'h2;
    localparam logic [1:0] SEG_MIDDLE = 2'h3;
    localparam logic [2:0] RESULT_LAST_BYTE = 3'h3;
    localparam logic [15:0] SEQ_RESET = 16'h0000;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_HDR = 2'b01,
        TX_PAY = 2'b11
    } tx_state_t;

    typedef enum logic {
        RX_HDR = 1'b0,
        RX_PAY = 1'b1
    } rx_state_t;

endpackage

`default_nettype wire

/* File: core/hdr_shift.sv */
// sixteen byte header shift register, loads whole or shifts one byte at a time
`default_nettype none

module hdr_shift (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [127:0] load_value,
    input wire logic shift,
    input wire logic [7:0] shift_in,
    output logic [127:0] value
);

    // ------------------------------------------------------------
    // storage, leaves the top byte first
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= 128'h0;
        end else if (load) begin
            value <= load_value;
        end else if (shift) begin
            value <= {value[119:0], shift_in};
        end
    end

endmodule // hdr_shift

`default_nettype wire

/* File: core/remoting_pdu_header_framer.sv */
// unit header builder and parser with payload pass-through
//
// Contract
// - transmitted version field is always zero
// - control flag set marks a control unit regardless of channel
// - extended unit without control still carries response, command and length
// - received reserved control bits are ignored
// - header carries a 24-bit channel identifier
// - header carries a 6-bit channel protocol type
// - received reserved header bits are ignored
// - segment position: 00 full, 01 first, 10 last, 11 middle
// - transmit sequence increments per unit, wrapping ffff to 0000
// - response flag set only in response units
// - response payload starts with a 32-bit result code
// - header carries a 5-bit command code
// - total length counts header plus payload bytes
// - requests report highest received sequence number
// - responses echo the request's sequence number
// - payload length is total length minus sixteen
// - extended channel payload passes through undecoded
`default_nettype none

module remoting_pdu_header_framer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tx_start,
    input wire remoting_pkg::hdr_t tx_hdr,
    input wire logic tx_seq_load,
    input wire logic [15:0] tx_seq_seed,
    input wire logic [15:0] tx_echo_seq,
    input wire logic tx_pay_valid,
    input wire logic [7:0] tx_pay_data,
    output logic tx_busy,
    output logic tx_pay_open,
    output logic [15:0] tx_next_seq,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output var remoting_pkg::hdr_t rx_hdr,
    output logic rx_hdr_valid,
    output logic [15:0] rx_pay_len,
    output logic rx_control_unit,
    output logic rx_len_error,
    output logic rx_version_error,
    output logic rx_seg_error,
    output logic [15:0] rx_highest_seq,
    output logic rx_pay_valid,
    output logic [7:0] rx_pay_data,
    output logic rx_pay_last,
    output logic rx_pay_opaque,
    output logic rx_result_valid,
    output logic [31:0] rx_result_code
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    remoting_pkg::tx_state_t tx_state;
    remoting_pkg::hdr_t tx_built;
    logic [127:0] tx_value;
    logic [3:0] tx_cnt;
    logic [15:0] tx_left;
    logic [15:0] tx_seq;
    logic tx_go;

    assign tx_go = tx_start && tx_state == remoting_pkg::TX_IDLE;

    always_comb begin
        tx_built = tx_hdr;
        tx_built.version = remoting_pkg::VERSION_ONE;
        tx_built.reserved_control_bits = remoting_pkg::RSV_CTRL_ZERO;
        tx_built.reserved_header_bits = remoting_pkg::RSV_HDR_ZERO;
        tx_built.sequence_number = tx_seq;
        // responses echo the request, requests report what was seen
        tx_built.received_sequence = tx_hdr.response_flag ? tx_echo_seq : rx_highest_seq;
    end

    hdr_shift tx_shift (
        .clk(clk),
        .rst_n(rst_n),
        .load(tx_go),
        .load_value(tx_built),
        .shift(tx_state == remoting_pkg::TX_HDR),
        .shift_in(8'h00),
        .value(tx_value)
    );

    // the seed only takes while idle so a unit never changes number mid-flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_seq <= remoting_pkg::SEQ_RESET;
        end else if (tx_go) begin
            tx_seq <= tx_seq + 16'h0001;
        end else if (tx_seq_load && tx_state == remoting_pkg::TX_IDLE) begin
            tx_seq <= tx_seq_seed;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= remoting_pkg::TX_IDLE;
            tx_cnt <= 4'h0;
            tx_left <= 16'h0;
            tx_pay_open <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 8'h00;
        end else begin
            out_valid <= 1'b0;
            unique case (tx_state)
                remoting_pkg::TX_IDLE: begin
                    if (tx_go) begin
                        tx_state <= remoting_pkg::TX_HDR;
                        tx_cnt <= 4'h0;
                        tx_left <= (tx_hdr.total_unit_length >= remoting_pkg::HDR_LEN) ?
                            tx_hdr.total_unit_length - remoting_pkg::HDR_LEN : 16'h0;
                    end
                end
                remoting_pkg::TX_HDR: begin
                    out_valid <= 1'b1;
                    out_data <= tx_value[127:120];
                    tx_cnt <= tx_cnt + 4'h1;
                    if (tx_cnt == remoting_pkg::HDR_LAST_BYTE) begin
                        tx_state <= (tx_left != 16'h0) ? remoting_pkg::TX_PAY : remoting_pkg::TX_IDLE;
                        tx_pay_open <= tx_left != 16'h0;
                    end
                end
                remoting_pkg::TX_PAY: begin
                    if (tx_pay_valid) begin
                        out_valid <= 1'b1;
                        out_data <= tx_pay_data;
                        tx_left <= tx_left - 16'h0001;
                        if (tx_left == 16'h0001) begin
                            tx_state <= remoting_pkg::TX_IDLE;
                            tx_pay_open <= 1'b0;
                        end
                    end
                end
                default: begin
                    tx_state <= remoting_pkg::TX_IDLE;
                    tx_pay_open <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy <= 1'b0;
            tx_next_seq <= remoting_pkg::SEQ_RESET;
        end else begin
            tx_busy <= tx_go || (tx_state != remoting_pkg::TX_IDLE && !(tx_state == remoting_pkg::TX_HDR
                && tx_cnt == remoting_pkg::HDR_LAST_BYTE && tx_left == 16'h0) && !(tx_state == remoting_pkg::TX_PAY
                && tx_pay_valid && tx_left == 16'h0001));
            tx_next_seq <= tx_seq;
        end
    end

    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    remoting_pkg::rx_state_t rx_state;
    remoting_pkg::hdr_t rx_full;
    logic [127:0] rx_value;
    logic [3:0] rx_cnt;
    logic [15:0] rx_left;
    logic [2:0] res_cnt;
    logic rx_take;
    logic in_seg;
    logic have_seq;
    logic [15:0] seq_diff;
    logic [34:0] seg_id;
    logic [34:0] full_id;
    logic seg_bad;

    assign rx_take = in_valid && rx_state == remoting_pkg::RX_HDR;
    assign rx_full = {rx_value[119:0], in_data};
    assign seq_diff = rx_full.sequence_number - rx_highest_seq;
    assign full_id = {rx_full.channel_identifier, rx_full.channel_protocol_type, rx_full.command_code};

    hdr_shift rx_shift (
        .clk(clk),
        .rst_n(rst_n),
        .load(1'b0),
        .load_value(128'h0),
        .shift(rx_take),
        .shift_in(in_data),
        .value(rx_value)
    );

    // order and identity of split payloads
    always_comb begin
        unique case (rx_full.segment_position_bits)
            remoting_pkg::SEG_FULL, remoting_pkg::SEG_FIRST: seg_bad = in_seg;
            remoting_pkg::SEG_LAST, remoting_pkg::SEG_MIDDLE: seg_bad = !in_seg || full_id != seg_id;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= remoting_pkg::RX_HDR;
            rx_cnt <= 4'h0;
            rx_left <= 16'h0;
            rx_hdr <= '0;
            rx_hdr_valid <= 1'b0;
            rx_pay_len <= 16'h0;
            rx_control_unit <= 1'b0;
            rx_len_error <= 1'b0;
            rx_version_error <= 1'b0;
            rx_seg_error <= 1'b0;
            rx_pay_opaque <= 1'b0;
            in_seg <= 1'b0;
            seg_id <= '0;
        end else begin
            rx_hdr_valid <= 1'b0;
            unique case (rx_state)
                remoting_pkg::RX_HDR: begin
                    if (rx_take) begin
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt == remoting_pkg::HDR_LAST_BYTE) begin
                            rx_hdr <= rx_full;
                            rx_hdr.reserved_control_bits <= remoting_pkg::RSV_CTRL_ZERO;
                            rx_hdr.reserved_header_bits <= remoting_pkg::RSV_HDR_ZERO;
                            rx_hdr_valid <= 1'b1;
                            rx_control_unit <= rx_full.control;
                            rx_pay_opaque <= !rx_full.control && rx_full.extended;
                            rx_version_error <= rx_full.version != remoting_pkg::VERSION_ONE;
                            rx_len_error <= rx_full.total_unit_length < remoting_pkg::HDR_LEN;
                            rx_pay_len <= (rx_full.total_unit_length >= remoting_pkg::HDR_LEN) ?
                                rx_full.total_unit_length - remoting_pkg::HDR_LEN : 16'h0;
                            rx_left <= (rx_full.total_unit_length > remoting_pkg::HDR_LEN) ?
                                rx_full.total_unit_length - remoting_pkg::HDR_LEN : 16'h0;
                            rx_seg_error <= seg_bad;
                            in_seg <= rx_full.segment_position_bits[0];
                            if (rx_full.segment_position_bits == remoting_pkg::SEG_FIRST) begin
                                seg_id <= full_id;
                            end
                            if (rx_full.total_unit_length > remoting_pkg::HDR_LEN) begin
                                rx_state <= remoting_pkg::RX_PAY;
                            end
                        end
                    end
                end
                remoting_pkg::RX_PAY: begin
                    if (in_valid) begin
                        rx_left <= rx_left - 16'h0001;
                        if (rx_left == 16'h0001) begin
                            rx_state <= remoting_pkg::RX_HDR;
                        end
                    end
                end
            endcase
        end
    end

    // payload bytes, and the leading result code of a response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_pay_valid <= 1'b0;
            rx_pay_data <= 8'h00;
            rx_pay_last <= 1'b0;
            rx_result_valid <= 1'b0;
            rx_result_code <= 32'h0;
            res_cnt <= 3'h0;
        end else begin
            rx_pay_valid <= in_valid && rx_state == remoting_pkg::RX_PAY;
            rx_pay_data <= in_data;
            rx_pay_last <= in_valid && rx_state == remoting_pkg::RX_PAY && rx_left == 16'h0001;
            rx_result_valid <= 1'b0;
            // restart while a header is read, so a payload byte right after it is kept
            if (rx_state == remoting_pkg::RX_HDR) begin
                res_cnt <= 3'h0;
            end else if (in_valid && rx_state == remoting_pkg::RX_PAY && rx_hdr.response_flag && !rx_pay_opaque
                && res_cnt <= remoting_pkg::RESULT_LAST_BYTE) begin
                rx_result_code <= {rx_result_code[23:0], in_data};
                res_cnt <= res_cnt + 3'h1;
                rx_result_valid <= res_cnt == remoting_pkg::RESULT_LAST_BYTE;
            end
        end
    end

    // highest sequence number seen, compared modulo the wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_highest_seq <= remoting_pkg::SEQ_RESET;
            have_seq <= 1'b0;
        end else if (rx_take && rx_cnt == remoting_pkg::HDR_LAST_BYTE && (!have_seq || !seq_diff[15])) begin
            rx_highest_seq <= rx_full.sequence_number;
            have_seq <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_version_zero: assert property (tx_go |=> ##1 (out_valid && out_data[7:5] == 3'h0))
        else $error("first header byte carries a nonzero version");
    a_seq_step: assert property (tx_go |=> tx_seq == $past(tx_seq) + 16'h0001)
        else $error("sequence did not step by one");
    a_header_run: assert property (tx_go |=> ##1 out_valid [*8] ##1 out_valid [*8])
        else $error("header bytes not sent back to back");
    a_request_rxseq: assert property (tx_go && !tx_hdr.response_flag |=>
        tx_value[15:0] == $past(rx_highest_seq))
        else $error("request does not report highest received sequence");
    a_response_echo: assert property (tx_go && tx_hdr.response_flag |=>
        tx_value[15:0] == $past(tx_echo_seq))
        else $error("response does not echo request sequence");
    a_payload_len: assert property (rx_hdr_valid |-> rx_pay_len == ((rx_hdr.total_unit_length >= 16'h0010) ?
        rx_hdr.total_unit_length - 16'h0010 : 16'h0))
        else $error("payload length is not total minus sixteen");
    a_rsv_ctrl: assert property (rx_hdr_valid |-> rx_hdr.reserved_control_bits == 3'h0)
        else $error("reserved control bits leak out");
    a_rsv_hdr: assert property (rx_hdr_valid |-> rx_hdr.reserved_header_bits == 2'h0)
        else $error("reserved header bits leak out");
    a_control_unit: assert property (rx_hdr_valid |-> rx_control_unit == rx_hdr.control)
        else $error("control unit flag mismatch");
    a_opaque_nodecode: assert property (rx_pay_opaque |-> !rx_result_valid)
        else $error("extended payload was decoded");

    c_tx_with_payload: cover property (tx_go ##[1:40] tx_pay_open);
    c_rx_response: cover property (rx_result_valid);
    c_rx_seg_error: cover property (rx_hdr_valid && rx_seg_error);
    c_rx_empty_unit: cover property (rx_hdr_valid && rx_pay_len == 16'h0);

endmodule // remoting_pdu_header_framer

`default_nettype wire

/* File: testbench/remote_node.sv */
// remote node model: feeds units into the framer and collects the bytes it sends
`default_nettype none

module remote_node (
    input wire logic clk,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic in_valid,
    output logic [7:0] in_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] seen[$];

    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
    end

    always @(posedge clk) begin
        if (out_valid === 1'b1) begin
            seen.push_back(out_data);
        end
    end

    // header most significant byte first, payload back to back
    task automatic send_unit(input remoting_pkg::hdr_t h, input int count);
        for (int i = 0; i < 16 + count; i++) begin
            @(negedge clk);
            in_valid = 1'b1;
            in_data = (i < 16) ? h[127 - 8 * i -: 8] : 8'(8'ha0 + i);
        end
        @(negedge clk);
        in_valid = 1'b0;
        // idle data is not a held copy of the last byte
        in_data = ~in_data;
    endtask
endmodule // remote_node

`default_nettype wire

/* File: testbench/remoting_pdu_header_framer_bench.sv */
// self-checking bench for the unit header framer
`default_nettype none

module remoting_pdu_header_framer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, nrst, tx_start, tx_seq_load, tx_pay_valid, in_valid;
    logic tx_busy, tx_pay_open, out_valid, rx_hdr_valid, rx_control_unit, rx_len_error;
    logic rx_version_error, rx_seg_error, rx_pay_valid, rx_pay_last, rx_pay_opaque, rx_result_valid;
    logic [7:0] tx_pay_data, out_data, in_data, rx_pay_data;
    logic [15:0] tx_seq_seed, tx_echo_seq, tx_next_seq, rx_pay_len, rx_highest_seq;
    logic [31:0] rx_result_code, got_code;
    remoting_pkg::hdr_t tx_hdr, rx_hdr, got_hdr;
    int err_count, comparisons, pay_count, last_count, result_count;

    remoting_pdu_header_framer dut (.clk(clk), .nrst(nrst), .tx_start(tx_start), .tx_hdr(tx_hdr),
        .tx_seq_load(tx_seq_load), .tx_seq_seed(tx_seq_seed), .tx_echo_seq(tx_echo_seq),
        .tx_pay_valid(tx_pay_valid), .tx_pay_data(tx_pay_data), .tx_busy(tx_busy), .tx_pay_open(tx_pay_open),
        .tx_next_seq(tx_next_seq), .out_valid(out_valid), .out_data(out_data), .in_valid(in_valid),
        .in_data(in_data), .rx_hdr(rx_hdr), .rx_hdr_valid(rx_hdr_valid), .rx_pay_len(rx_pay_len),
        .rx_control_unit(rx_control_unit), .rx_len_error(rx_len_error), .rx_version_error(rx_version_error),
        .rx_seg_error(rx_seg_error), .rx_highest_seq(rx_highest_seq), .rx_pay_valid(rx_pay_valid),
        .rx_pay_data(rx_pay_data), .rx_pay_last(rx_pay_last), .rx_pay_opaque(rx_pay_opaque),
        .rx_result_valid(rx_result_valid), .rx_result_code(rx_result_code));

    remote_node node (.clk(clk), .out_valid(out_valid), .out_data(out_data), .in_valid(in_valid),
        .in_data(in_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // receive monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rx_hdr_valid === 1'b1) begin
            got_hdr = rx_hdr;
        end
        if (rx_pay_valid === 1'b1) begin
            chk("pay data", 32'(8'(8'hb0 + pay_count)), 32'(rx_pay_data));
            pay_count++;
        end
        if (rx_pay_last === 1'b1) begin
            last_count++;
        end
        if (rx_result_valid === 1'b1) begin
            result_count++;
            got_code = rx_result_code;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic remoting_pkg::hdr_t mk(input logic [1:0] cx, input logic [1:0] seg, input logic rs,
        input logic [15:0] total, input logic [15:0] seq);
        remoting_pkg::hdr_t h;
        h = '0;
        {h.control, h.extended} = cx;
        h.reserved_control_bits = 3'h5;
        h.channel_identifier = 24'habcdef;
        h.channel_protocol_type = 6'h2a;
        h.reserved_header_bits = 2'h3;
        h.segment_position_bits = seg;
        h.response_flag = rs;
        h.command_code = 5'h0b;
        h.total_unit_length = total;
        h.sequence_number = seq;
        return h;
    endfunction

    task automatic rx_unit(input remoting_pkg::hdr_t h, input int n);
        pay_count = 0;
        last_count = 0;
        result_count = 0;
        node.send_unit(h, n);
        repeat (3) @(negedge clk);
    endtask

    task automatic tx_unit(input remoting_pkg::hdr_t h, input int n, input logic [15:0] seq,
        input logic [15:0] rxs);
        remoting_pkg::hdr_t e;
        int sent;
        int k;
        e = h;
        e.version = 3'h0;
        e.reserved_control_bits = 3'h0;
        e.reserved_header_bits = 2'h0;
        e.sequence_number = seq;
        e.received_sequence = rxs;
        node.seen.delete();
        tx_hdr = h;
        tx_start = 1'b1;
        @(negedge clk);
        tx_start = 1'b0;
        @(negedge clk);
        sent = 0;
        k = 0;
        while ((sent < n || tx_busy !== 1'b0) && k < 300) begin
            tx_pay_valid = (tx_pay_open === 1'b1 && sent < n);
            tx_pay_data = 8'(8'h50 + sent);
            if (tx_pay_valid) begin
                sent++;
            end
            @(negedge clk);
            k++;
        end
        tx_pay_valid = 1'b0;
        if (k >= 300) begin
            err_count++;
            close_out();
        end
        repeat (3) @(negedge clk);
        chk("out count", 32'(16 + n), 32'(node.seen.size()));
        for (int i = 0; i < node.seen.size() && i < 16 + n; i++) begin
            chk("out byte", (i < 16) ? 32'(e[127 - 8 * i -: 8]) : 32'(8'h50 + i - 16), 32'(node.seen[i]));
        end
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        remoting_pkg::hdr_t h;
        err_count = 0;
        comparisons = 0;
        nrst = 1'b0;
        tx_start = 1'b0;
        tx_hdr = '0;
        tx_seq_load = 1'b0;
        tx_seq_seed = 16'h0000;
        tx_echo_seq = 16'h0000;
        tx_pay_valid = 1'b0;
        tx_pay_data = 8'h00;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        h = mk(2'b00, 2'h0, 1'b0, 16'h0010, 16'h1200);
        h.version = 3'h5;
        rx_unit(h, 0);
        chk("version error", 32'h1, 32'(rx_version_error));
        rx_unit(mk(2'b00, 2'h0, 1'b0, 16'h0008, 16'h1201), 0);
        chk("len error", 32'h1, 32'(rx_len_error));
        chk("pay len short", 32'h0, 32'(rx_pay_len));
        h = mk(2'b10, 2'h0, 1'b1, 16'h0016, 16'h1230);
        rx_unit(h, 6);
        h.reserved_control_bits = 3'h0;
        h.reserved_header_bits = 2'h0;
        for (int w = 0; w < 4; w++) begin
            chk("rx_hdr word", h[127 - 32 * w -: 32], got_hdr[127 - 32 * w -: 32]);
        end
        chk("control unit", 32'h1, 32'(rx_control_unit));
        chk("pay len", 32'h6, 32'(rx_pay_len));
        chk("pay bytes", 32'h6, 32'(pay_count));
        chk("pay last", 32'h1, 32'(last_count));
        chk("result code", 32'hb0b1b2b3, got_code);
        chk("result pulses", 32'h1, 32'(result_count));
        chk("opaque std", 32'h0, 32'(rx_pay_opaque));
        rx_unit(mk(2'b01, 2'h0, 1'b1, 16'h0014, 16'h1231), 4);
        chk("opaque ext", 32'h1, 32'(rx_pay_opaque));
        chk("ext result", 32'h0, 32'(result_count));
        chk("ext control", 32'h0, 32'(rx_control_unit));
        chk("ext command", 32'h0b, 32'(got_hdr.command_code));
        chk("ext bytes", 32'h4, 32'(pay_count));
        rx_unit(mk(2'b00, 2'h0, 1'b0, 16'h0010, 16'h1232), 0);
        chk("empty len", 32'h0, 32'(rx_pay_len));
        chk("empty bytes", 32'h0, 32'(pay_count));
        chk("empty len error", 32'h0, 32'(rx_len_error));
        for (int s = 0; s < 3; s++) begin
            rx_unit(mk(2'b00, (s == 0) ? 2'h1 : (s == 1) ? 2'h3 : 2'h2, 1'b0, 16'h0012, 16'(16'h1233 + s)), 2);
            chk("seg order ok", 32'h0, 32'(rx_seg_error));
        end
        rx_unit(mk(2'b00, 2'h3, 1'b0, 16'h0012, 16'h1236), 2);
        chk("seg stray middle", 32'h1, 32'(rx_seg_error));
        chk("highest seq", 32'h1236, 32'(rx_highest_seq));
        tx_seq_seed = 16'hfffe;
        tx_seq_load = 1'b1;
        @(negedge clk);
        tx_seq_load = 1'b0;
        @(negedge clk);
        h = mk(2'b00, 2'h0, 1'b0, 16'h0013, 16'h7777);
        h.version = 3'h7;
        tx_unit(h, 3, 16'hfffe, 16'h1236);
        chk("next seq", 32'hffff, 32'(tx_next_seq));
        tx_echo_seq = 16'h4321;
        h = mk(2'b10, 2'h1, 1'b1, 16'h0014, 16'h0000);
        h.channel_timestamp = 32'h01020304;
        tx_unit(h, 4, 16'hffff, 16'h4321);
        tx_unit(mk(2'b01, 2'h0, 1'b0, 16'h0010, 16'h0000), 0, 16'h0000, 16'h1236);
        close_out();
    end
endmodule // remoting_pdu_header_framer_bench

`default_nettype wire
